/* File: src/lesync_top.v */
// Paged per-lane error and code group sync status block
// Summary of operation
// - Each lane has a read-only invalid-code flag that is 1 when its error count is at or above the 8-bit threshold.
// - Each lane has a read-only unexpected control-character flag that is 1 when its count is at or above the threshold.
// - Each lane reports code group sync as one read-only bit, 1 for achieved and 0 for lost.
// - All per-lane status reads return the values of the link chosen by the link page register.
// - In every 8-bit status register the flag of lane n sits at bit n.
//
// Strobed register access is this design's own decision.
`include "lesync_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module lesync_top #(
  parameter NUM_LINKS = 2,
  parameter PAGE_W = 1,
  parameter LANES = 8,
  parameter CNT_W = 8
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [`LESYNC_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire [NUM_LINKS*LANES-1:0] nit_err_i,
  input wire [NUM_LINKS*LANES-1:0] kchar_err_i,
  input wire [NUM_LINKS*LANES-1:0] code_lock_i,
  output wire irq_o
);

  // ==========================================================
  // Page selection helper
  function [LANES-1:0] pick_link;
    input [NUM_LINKS*LANES-1:0] v;
    input [PAGE_W-1:0] p;
    integer k;
    begin
      pick_link = {LANES{1'b0}};
      for (k = 0; k < NUM_LINKS; k = k + 1) begin
        if (p == k[PAGE_W-1:0]) begin
          pick_link = v[k*LANES +: LANES];
        end
      end
    end
  endfunction

  // ==========================================================
  // Software registers
  reg [PAGE_W-1:0] page_r;
  reg [CNT_W-1:0] thr_r;
  reg [`LESYNC_IRQ_W-1:0] ist_r;
  reg [`LESYNC_IRQ_W-1:0] ist_nxt;
  reg [`LESYNC_IRQ_W-1:0] imsk_r;
  reg [NUM_LINKS*LANES-1:0] lock_r;
  reg [NUM_LINKS*LANES-1:0] nit_prev_r;
  reg [NUM_LINKS*LANES-1:0] uek_prev_r;
  wire [NUM_LINKS*LANES-1:0] nit_flags;
  wire [NUM_LINKS*LANES-1:0] uek_flags;
  wire clr_cnt;
  wire [`LESYNC_IRQ_W-1:0] ev;

  assign clr_cnt = wr_i && (addr_i == `LESYNC_OFF_CLR) && wdata_i[`LESYNC_CLR_BIT];

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      page_r <= {PAGE_W{1'b0}};
      thr_r <= `LESYNC_RST_THR;
      imsk_r <= `LESYNC_RST_IRQ;
    end else if (wr_i) begin
      case (addr_i)
        `LESYNC_OFF_PAGE: begin
          page_r <= wdata_i[PAGE_W-1:0];
        end
        `LESYNC_OFF_THR: begin
          thr_r <= wdata_i[CNT_W-1:0];
        end
        `LESYNC_OFF_IMSK: begin
          imsk_r <= wdata_i[`LESYNC_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Counters, one bank per link and error kind
  genvar l;
  generate
    for (l = 0; l < NUM_LINKS; l = l + 1) begin : g_link
      lesync_lane_cnt #(.LANES(LANES), .CNT_W(CNT_W)) u_nit (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .clr_i(clr_cnt),
        .err_i(nit_err_i[l*LANES +: LANES]),
        .thr_i(thr_r),
        .flag_o(nit_flags[l*LANES +: LANES])
      );
      lesync_lane_cnt #(.LANES(LANES), .CNT_W(CNT_W)) u_uek (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .clr_i(clr_cnt),
        .err_i(kchar_err_i[l*LANES +: LANES]),
        .thr_i(thr_r),
        .flag_o(uek_flags[l*LANES +: LANES])
      );
    end
  endgenerate

  // ==========================================================
  // Lock status and event detection
  // Lock is registered so a read never sees a half-updated lane set
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      lock_r <= {(NUM_LINKS*LANES){1'b0}};
      nit_prev_r <= {(NUM_LINKS*LANES){1'b0}};
      uek_prev_r <= {(NUM_LINKS*LANES){1'b0}};
    end else begin
      lock_r <= code_lock_i;
      nit_prev_r <= nit_flags;
      uek_prev_r <= uek_flags;
    end
  end

  assign ev[`LESYNC_IRQ_NIT] = |(nit_flags & ~nit_prev_r);
  assign ev[`LESYNC_IRQ_UEK] = |(uek_flags & ~uek_prev_r);
  assign ev[`LESYNC_IRQ_LOSS] = |(lock_r & ~code_lock_i);

  // Set beats a same-cycle write-one clear
  always @* begin
    ist_nxt = ist_r;
    if (wr_i && (addr_i == `LESYNC_OFF_IST)) begin
      ist_nxt = ist_nxt & ~wdata_i[`LESYNC_IRQ_W-1:0];
    end
    ist_nxt = ist_nxt | ev;
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      ist_r <= `LESYNC_RST_IRQ;
    end else begin
      ist_r <= ist_nxt;
    end
  end

  assign irq_o = |(ist_r & imsk_r);

  // ==========================================================
  // Read port, data valid only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o <= `LESYNC_RST_FLAGS;
    end else if (rd_i) begin
      case (addr_i)
        `LESYNC_OFF_NIT: begin
          rdata_o <= pick_link(nit_flags, page_r);
        end
        `LESYNC_OFF_UEK: begin
          rdata_o <= pick_link(uek_flags, page_r);
        end
        `LESYNC_OFF_CGS: begin
          rdata_o <= pick_link(lock_r, page_r);
        end
        `LESYNC_OFF_PAGE: begin
          rdata_o <= {{(8-PAGE_W){1'b0}}, page_r};
        end
        `LESYNC_OFF_THR: begin
          rdata_o <= thr_r;
        end
        `LESYNC_OFF_IST: begin
          rdata_o <= {{(8-`LESYNC_IRQ_W){1'b0}}, ist_r};
        end
        `LESYNC_OFF_IMSK: begin
          rdata_o <= {{(8-`LESYNC_IRQ_W){1'b0}}, imsk_r};
        end
        default: begin
          rdata_o <= `LESYNC_RST_FLAGS;
        end
      endcase
    end else begin
      rdata_o <= `LESYNC_RST_FLAGS;
    end
  end

endmodule // lesync_top

`default_nettype wire

/* File: src/lesync_consts.vh */
// Constants for the lane error and sync status block
`ifndef LESYNC_CONSTS_VH
`define LESYNC_CONSTS_VH

// ==========================================================
// Register offsets
`define LESYNC_ADDR_W 12
`define LESYNC_OFF_PAGE 12'h0300
`define LESYNC_OFF_NIT 12'h046E
`define LESYNC_OFF_UEK 12'h046F
`define LESYNC_OFF_CGS 12'h0470
`define LESYNC_OFF_THR 12'h0478
`define LESYNC_OFF_CLR 12'h0479
`define LESYNC_OFF_IST 12'h047A
`define LESYNC_OFF_IMSK 12'h047B

// ==========================================================
// Reset values and fields
`define LESYNC_RST_THR 8'hFF
`define LESYNC_RST_FLAGS 8'h00
`define LESYNC_RST_IRQ 3'h0
`define LESYNC_IRQ_W 3
`define LESYNC_IRQ_NIT 0
`define LESYNC_IRQ_UEK 1
`define LESYNC_IRQ_LOSS 2
`define LESYNC_CLR_BIT 0

`endif

/* File: src/lesync_lane_cnt.v */
// Saturating per-lane error counters with threshold compare
`timescale 1ns/1ns
`default_nettype none

module lesync_lane_cnt #(
  parameter LANES = 8,
  parameter CNT_W = 8
) (
  input wire clk_i,
  input wire nrst_i,
  input wire clr_i,
  input wire [LANES-1:0] err_i,
  input wire [CNT_W-1:0] thr_i,
  output wire [LANES-1:0] flag_o
);

  genvar g;

  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      // One counter per lane, so each register has a single driving process
      reg [CNT_W-1:0] cnt_r;
      wire [CNT_W-1:0] cur;
      wire sat;
      assign cur = cnt_r;
      assign sat = &cur;
      // Error in the clear cycle is kept as the first count
      always @(posedge clk_i) begin
        if (!nrst_i) begin
          cnt_r <= {CNT_W{1'b0}};
        end else if (clr_i) begin
          cnt_r <= {{(CNT_W-1){1'b0}}, err_i[g]};
        end else if (err_i[g] && !sat) begin
          cnt_r <= cur + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      // Lane n result sits on bit n
      assign flag_o[g] = (cur >= thr_i);
    end
  endgenerate

endmodule // lesync_lane_cnt

`default_nettype wire

/* File: tb/lesync_chk.sv */
// Port-level assertions for the lane status block
`timescale 1ns/1ns
`default_nettype none
module lesync_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [15:0] code_lock_i,
  input wire logic irq_o
);
  logic pg_r;
  logic [7:0] thr_r;
  logic [7:0] msk_r;
  // Shadow copies, so no check reaches into the design
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pg_r <= 1'b0;
      thr_r <= 8'hff;
      msk_r <= 8'h00;
    end else if (wr_i) begin
      if (addr_i == 12'h0300) pg_r <= wdata_i[0];
      if (addr_i == 12'h0478) thr_r <= wdata_i;
      if (addr_i == 12'h047b) msk_r <= wdata_i;
    end
  end
  // ==========
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Lock input must be steady across the register stage
  sequence s_lock_rd;
    (rd_i && addr_i == 12'h0470 && $stable(code_lock_i)) ##1 $stable(code_lock_i);
  endsequence
  AST_LOCK_RD: assert property (s_lock_rd |-> rdata_o == code_lock_i[pg_r*8 +: 8])
    else $error("lock flags differ from lane inputs");
  AST_NIT_T0: assert property (rd_i && addr_i == 12'h046e && thr_r == 8'h00 |=> rdata_o == 8'hff)
    else $error("invalid code flags low at zero threshold");
  AST_UEK_T0: assert property (rd_i && addr_i == 12'h046f && thr_r == 8'h00 |=> rdata_o == 8'hff)
    else $error("control char flags low at zero threshold");
  AST_THR_RD: assert property (rd_i && addr_i == 12'h0478 |=> rdata_o == thr_r)
    else $error("threshold readback wrong");
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  AST_IRQ_MSK: assert property (msk_r == 8'h00 |-> !irq_o)
    else $error("interrupt with all sources masked");
endmodule // lesync_chk
`default_nettype wire

/* File: tb/lesync_link_mdl.sv */
// Link transmitter model: error pulses and lock levels
`timescale 1ns/1ns
`default_nettype none
module lesync_link_mdl (
  input wire logic clk_i,
  input wire logic [15:0] nit_req_i,
  input wire logic [15:0] kch_req_i,
  input wire logic [15:0] lock_req_i,
  output logic [15:0] nit_err_o,
  output logic [15:0] kchar_err_o,
  output logic [15:0] code_lock_o
);
  // One request cycle gives exactly one clock-wide error pulse
  always_ff @(posedge clk_i) begin
    nit_err_o <= nit_req_i;
    kchar_err_o <= kch_req_i;
    code_lock_o <= lock_req_i;
  end
endmodule // lesync_link_mdl
`default_nettype wire

/* File: tb/lesync_tb_top.sv */
// Self-checking bench for the lane status block
`timescale 1ns/1ns
`default_nettype none
module lesync_tb_top;
  logic clk_i = 0, nrst_i = 0, wr = 0, rd = 0, rv = 0, irq;
  logic [11:0] ad = 0;
  logic [7:0] wd = 0, rdata, m;
  logic [15:0] nq = 0, kq = 0, lq = 0, nit, kch, lock, s = 16'he47e;
  logic [7:0] q[$];
  int miscompares = 0, total_checks = 0;
  always #10 clk_i = ~clk_i;
  function automatic [15:0] lfsr(input [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  lesync_top lesync_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(ad), .wdata_i(wd),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .nit_err_i(nit), .kchar_err_i(kch),
    .code_lock_i(lock), .irq_o(irq));
  lesync_link_mdl lesync_link_mdl_inst (.clk_i(clk_i), .nit_req_i(nq), .kch_req_i(kq),
    .lock_req_i(lq), .nit_err_o(nit), .kchar_err_o(kch), .code_lock_o(lock));
  task chk(input string nm, input [7:0] e, input [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task report_and_stop;
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task wrt(input [11:0] a, input [7:0] d);
    @(posedge clk_i);
    {ad, wd, wr} <= {a, d, 1'b1};
    @(posedge clk_i);
    wr <= 0;
  endtask
  task rdx(input [11:0] a, input [7:0] e);
    @(posedge clk_i);
    {ad, rd} <= {a, 1'b1};
    q.push_back(e);
    @(posedge clk_i);
    rd <= 0;
  endtask
  task pls(input [15:0] a, input [15:0] b, input int c);
    @(posedge clk_i);
    {nq, kq} <= {a, b};
    repeat (c) @(posedge clk_i);
    {nq, kq} <= 32'h0000_0000;
    repeat (3) @(posedge clk_i);
  endtask
  always @(posedge clk_i) rv <= rd;
  always @(negedge clk_i) if (rv) chk("rdata_o", q.pop_front(), rdata);
  task irqc(input [7:0] e);
    @(negedge clk_i);
    chk("irq_o", e, {7'h00, irq});
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1;
    rdx(12'h0478, 8'hff);
    rdx(12'h046f, 8'h00);
    rdx(12'h0470, 8'h00);
    wrt(12'h046e, 8'hff);
    rdx(12'h046e, 8'h00);
    rdx(12'h0123, 8'h00);
    wrt(12'h0478, 8'h00);
    rdx(12'h046e, 8'hff);
    rdx(12'h046f, 8'hff);
    wrt(12'h0478, 8'h02);
    s = lfsr(s);
    m = s[7:0] | 8'h80;
    pls({8'h00, m | s[15:8]}, {m | s[15:8], 8'h00}, 1);
    pls({8'h00, m}, {m, 8'h00}, 1);
    rdx(12'h046e, m);
    rdx(12'h046f, 8'h00);
    wrt(12'h0300, 8'h01);
    rdx(12'h046f, m);
    rdx(12'h046e, 8'h00);
    s = lfsr(s);
    lq <= s;
    repeat (4) @(posedge clk_i);
    rdx(12'h0470, s[15:8]);
    wrt(12'h0300, 8'h00);
    rdx(12'h0470, s[7:0]);
    irqc(8'h00);
    wrt(12'h047b, 8'h01);
    irqc(8'h01);
    wrt(12'h047a, 8'h01);
    irqc(8'h00);
    wrt(12'h0478, 8'hff);
    wrt(12'h0479, 8'h01);
    rdx(12'h046e, 8'h00);
    pls(16'h0002, 16'h0000, 300);
    rdx(12'h046e, 8'h02);
    report_and_stop;
  end
endmodule // lesync_tb_top
bind lesync_top lesync_chk lesync_chk_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .code_lock_i(code_lock_i),
  .irq_o(irq_o));
`default_nettype wire
